/* File: rtl/dprc_ram.sv */
// dprc_ram: ram block with selectable port clocking, clock enables and clears.
// assumes user logic on clk_i drives every input, port clocks as one-cycle ticks.
`timescale 1ns/100ps
module dprc_ram #(
  parameter int ADDR_W      = 8,
  parameter int DATA_W      = 16,
  parameter bit USE_BYTEEN  = 1'b1
) (
  input  wire logic                                  clk_i,
  input  wire logic                                  reset_i,
  input  wire logic [1:0]                            mode_i,
  input  wire logic                                  sdp_i,
  input  wire logic                                  out_bypass_i,
  input  wire logic                                  a_in_tick_i,
  input  wire logic                                  a_in_ce_i,
  input  wire logic                                  a_in_clr_i,
  input  wire logic                                  a_out_tick_i,
  input  wire logic                                  a_out_ce_i,
  input  wire logic                                  a_out_clr_i,
  input  wire logic [ADDR_W-1:0]                     a_addr_i,
  input  wire logic [DATA_W-1:0]                     a_wdata_i,
  input  wire logic                                  a_wren_i,
  input  wire logic [DATA_W/dprc_pkg::DPRC_LANE_W-1:0] a_byteen_i,
  output logic      [DATA_W-1:0]                     a_rdata_o,
  input  wire logic                                  b_in_tick_i,
  input  wire logic                                  b_in_ce_i,
  input  wire logic                                  b_in_clr_i,
  input  wire logic                                  b_out_tick_i,
  input  wire logic                                  b_out_ce_i,
  input  wire logic                                  b_out_clr_i,
  input  wire logic [ADDR_W-1:0]                     b_addr_i,
  input  wire logic [DATA_W-1:0]                     b_wdata_i,
  input  wire logic                                  b_wren_i,
  input  wire logic                                  b_rden_i,
  input  wire logic [DATA_W/dprc_pkg::DPRC_LANE_W-1:0] b_byteen_i,
  output logic      [DATA_W-1:0]                     b_rdata_o
);
  localparam int NP    = dprc_pkg::DPRC_NPORTS;
  localparam int LANES = DATA_W / dprc_pkg::DPRC_LANE_W;
  localparam int HALF_BITS = (2**(ADDR_W-1)) * DATA_W;

  // the mode pins are levels; changing them mid-access is not supported
  dprc_pkg::dprc_mode_e mode;
  logic                 sdp;
  assign mode = dprc_pkg::dprc_mode_e'(mode_i);
  // simple dual-port: a writes only, b reads only under its read strobe
  assign sdp  = (mode == dprc_pkg::DPRC_MODE_RW) ||
                ((mode == dprc_pkg::DPRC_MODE_IO) && sdp_i);

  // per-port views of the user inputs
  logic [NP-1:0]     in_tick, in_ce, in_clr, out_tick, out_ce, out_clr, wren_in;
  logic [ADDR_W-1:0] addr_in  [NP];
  logic [DATA_W-1:0] wdata_in [NP];
  logic [LANES-1:0]  be_in    [NP];
  assign in_tick  = {b_in_tick_i, a_in_tick_i};
  assign in_ce    = {b_in_ce_i, a_in_ce_i};
  assign in_clr   = {b_in_clr_i, a_in_clr_i};
  assign out_tick = {b_out_tick_i, a_out_tick_i};
  assign out_ce   = {b_out_ce_i, a_out_ce_i};
  assign out_clr  = {b_out_clr_i, a_out_clr_i};
  assign wren_in  = {b_wren_i, a_wren_i};
  assign addr_in[0]  = a_addr_i;
  assign addr_in[1]  = b_addr_i;
  assign wdata_in[0] = a_wdata_i;
  assign wdata_in[1] = b_wdata_i;
  assign be_in[0]    = a_byteen_i;
  assign be_in[1]    = b_byteen_i;

  // port-side registers
  logic [ADDR_W-1:0] addr_reg  [NP];
  logic [DATA_W-1:0] wdata_reg [NP];
  logic [LANES-1:0]  be_reg    [NP];
  logic [NP-1:0]     wren_reg, acc_reg;
  logic              rden_reg;
  logic [DATA_W-1:0] out_reg   [NP];
  logic [DATA_W-1:0] mem_q     [NP];
  logic [DATA_W-1:0] rdata     [NP];

  // memory-side controls
  logic [NP-1:0]     mem_we, mem_re, in_stb, out_stb, oclr, wr_ok, rd_ok;
  logic [ADDR_W-1:0] mem_addr  [NP];
  logic [LANES-1:0]  mem_be    [NP];

  // rden only exists on b; stored on the read clock, never cleared
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rden_reg <= 1'b0;
    end else if (in_stb[dprc_pkg::DPRC_PORT_B]) begin
      rden_reg <= b_rden_i;
    end
  end

  for (genvar g = 0; g < NP; g++) begin : g_port
    // io mode gives the output register its own clock, enable and clear;
    // every other mode runs the whole port side from the port's one clock
    assign in_stb[g]  = in_tick[g] && in_ce[g];
    assign out_stb[g] = (mode == dprc_pkg::DPRC_MODE_IO) ?
                        (out_tick[g] && out_ce[g]) : in_stb[g];
    assign oclr[g]    = (mode == dprc_pkg::DPRC_MODE_IO) ? out_clr[g] : in_clr[g];

    // all input registers share one strobe, so they always move together
    always_ff @(posedge clk_i) begin
      if (reset_i || in_clr[g]) begin
        addr_reg[g]  <= '0;
        wdata_reg[g] <= '0;
        be_reg[g]    <= '0;
        wren_reg[g]  <= 1'b0;
      end else if (in_stb[g]) begin
        addr_reg[g]  <= addr_in[g];
        wdata_reg[g] <= wdata_in[g];
        be_reg[g]    <= be_in[g];
        wren_reg[g]  <= wren_in[g];
      end
    end

    // the array acts on the cycle after capture; a clear in the capture cycle cancels it
    // one cycle of latency buys a clean cut between capture and array access
    always_ff @(posedge clk_i) begin
      if (reset_i) begin
        acc_reg[g] <= 1'b0;
      end else begin
        acc_reg[g] <= in_stb[g] && !in_clr[g];
      end
    end

    assign wr_ok[g] = !(sdp && (g == dprc_pkg::DPRC_PORT_B));
    assign rd_ok[g] = sdp ? ((g == dprc_pkg::DPRC_PORT_B) && rden_reg) : 1'b1;
    // the write strobe alone picks the direction of a true port
    assign mem_we[g] = acc_reg[g] && wren_reg[g] && wr_ok[g];
    assign mem_re[g] = acc_reg[g] && !wren_reg[g] && rd_ok[g];
    assign mem_be[g] = USE_BYTEEN ? be_reg[g] : {LANES{1'b1}};
    // single-port: port number replaces the top address bit, one memory per port
    assign mem_addr[g] = (mode == dprc_pkg::DPRC_MODE_SINGLE) ?
                         {1'(g), addr_reg[g][ADDR_W-2:0]} : addr_reg[g];

    always_ff @(posedge clk_i) begin
      if (reset_i || oclr[g]) begin
        out_reg[g] <= '0;
      end else if (out_stb[g]) begin
        out_reg[g] <= mem_q[g];
      end
    end

    // clear is masked in combinationally so it shows without waiting an edge
    // limitation: with bypass on, a clear zeroes the pins but not the array register
    assign rdata[g] = oclr[g] ? '0 :
                      (out_bypass_i ? mem_q[g] : out_reg[g]);

    a_in_hold_ce: assert property (@(posedge clk_i) disable iff (reset_i)
      !in_stb[g] && !in_clr[g] |=> $stable(addr_reg[g]) && $stable(wdata_reg[g]))
      else $error("input register moved without enable");

    a_in_capture: assert property (@(posedge clk_i) disable iff (reset_i)
      in_stb[g] && !in_clr[g] |=> addr_reg[g] == $past(addr_in[g]) &&
                                  wren_reg[g] == $past(wren_in[g]))
      else $error("input register missed its strobe");

    a_in_clear: assert property (@(posedge clk_i) disable iff (reset_i)
      in_clr[g] |=> addr_reg[g] == '0 && !wren_reg[g] && !acc_reg[g])
      else $error("input clear did not zero the port");

    a_out_clear_now: assert property (@(posedge clk_i) disable iff (reset_i)
      oclr[g] |-> rdata[g] == '0)
      else $error("output clear not immediate");

    a_out_capture: assert property (@(posedge clk_i) disable iff (reset_i)
      out_stb[g] && !oclr[g] ##1 !out_bypass_i && !oclr[g]
        |-> rdata[g] == $past(mem_q[g]))
      else $error("output register missed its clock");

    a_out_hold: assert property (@(posedge clk_i) disable iff (reset_i)
      !out_stb[g] && !oclr[g] |=> $stable(out_reg[g]))
      else $error("output register moved without enable");

    a_single_split: assert property (@(posedge clk_i) disable iff (reset_i)
      mode == dprc_pkg::DPRC_MODE_SINGLE && acc_reg[g]
        |-> mem_addr[g][ADDR_W-1] == 1'(g) && HALF_BITS <= dprc_pkg::DPRC_SP_MAX_BITS)
      else $error("single-port memory leaves its half");

    // a write taken on a writable port must reach the array on the next cycle
    sequence s_wr_take;
      in_stb[g] && !in_clr[g] && wren_in[g] && wr_ok[g];
    endsequence

    sequence s_rd_true;
      in_stb[g] && !in_clr[g] && !wren_in[g] && !sdp;
    endsequence

    a_wr_issue: assert property (@(posedge clk_i) disable iff (reset_i)
      s_wr_take |=> mem_we[g] && !mem_re[g])
      else $error("captured write never reached the array");

    a_rd_issue: assert property (@(posedge clk_i) disable iff (reset_i)
      s_rd_true |=> mem_re[g] && !mem_we[g])
      else $error("captured read never reached the array");

    a_clr_cancel: assert property (@(posedge clk_i) disable iff (reset_i)
      in_clr[g] |=> !mem_we[g] && !mem_re[g])
      else $error("cleared port still reached the array");

    a_bypass_path: assert property (@(posedge clk_i) disable iff (reset_i)
      out_bypass_i && !oclr[g] |-> rdata[g] == mem_q[g])
      else $error("bypass did not show array data");

    // io mode clears the output side from its own pin, others from the port clear
    a_io_out_clear: assert property (@(posedge clk_i) disable iff (reset_i)
      mode == dprc_pkg::DPRC_MODE_IO && out_clr[g] |-> rdata[g] == '0)
      else $error("output-side clear ignored");

    a_port_clear: assert property (@(posedge clk_i) disable iff (reset_i)
      mode != dprc_pkg::DPRC_MODE_IO && in_clr[g] |-> rdata[g] == '0)
      else $error("port clear left read data");

    a_io_out_clock: assert property (@(posedge clk_i) disable iff (reset_i)
      mode == dprc_pkg::DPRC_MODE_IO && !(out_tick[g] && out_ce[g]) && !out_clr[g]
        |=> $stable(out_reg[g]))
      else $error("output register moved off its own clock");
  end

  // port outputs are plain views of the per-port read data
  assign a_rdata_o = rdata[dprc_pkg::DPRC_PORT_A];
  assign b_rdata_o = rdata[dprc_pkg::DPRC_PORT_B];

  // array read data is registered, so a read answers one edge after capture
  dprc_mem #(
    .ADDR_W (ADDR_W),
    .DATA_W (DATA_W)
  ) u_mem (
    .clk_i     (clk_i),
    .reset_i   (reset_i),
    .a_we_i    (mem_we[0]),
    .a_re_i    (mem_re[0]),
    .a_addr_i  (mem_addr[0]),
    .a_wdata_i (wdata_reg[0]),
    .a_be_i    (mem_be[0]),
    .a_q_o     (mem_q[0]),
    .b_we_i    (mem_we[1]),
    .b_re_i    (mem_re[1]),
    .b_addr_i  (mem_addr[1]),
    .b_wdata_i (wdata_reg[1]),
    .b_be_i    (mem_be[1]),
    .b_q_o     (mem_q[1])
  );

  sequence s_rd_take;
    in_stb[1] && !in_clr[1] && b_rden_i;
  endsequence

  sequence s_rd_access;
    ##1 acc_reg[1] && rden_reg;
  endsequence

  a_sdp_read_path: assert property (@(posedge clk_i) disable iff (reset_i)
    (s_rd_take and sdp) ##0 !b_wren_i |-> s_rd_access ##0 mem_re[1])
    else $error("read strobe did not start a read");

  a_sdp_b_nowrite: assert property (@(posedge clk_i) disable iff (reset_i)
    sdp |-> !mem_we[1] && !(mem_re[0]))
    else $error("simple dual-port port direction broken");

  a_rden_noclear: assert property (@(posedge clk_i) disable iff (reset_i)
    in_clr[1] && !in_stb[1] |=> $stable(rden_reg))
    else $error("read strobe register was cleared");

  a_no_read_on_write: assert property (@(posedge clk_i) disable iff (reset_i)
    mem_we[0] |-> !mem_re[0])
    else $error("port read while writing");

  a_lane_default: assert property (@(posedge clk_i) disable iff (reset_i)
    !USE_BYTEEN |-> &mem_be[0] && &mem_be[1])
    else $error("unused lane enables not all high");

  a_indep_isolation: assert property (@(posedge clk_i) disable iff (reset_i)
    mode == dprc_pkg::DPRC_MODE_INDEP && !in_stb[1] && !in_clr[1] && in_stb[0]
      |=> $stable(addr_reg[1]) && $stable(out_reg[1]))
    else $error("port a clock moved port b registers");

  a_sdp_out_clear: assert property (@(posedge clk_i) disable iff (reset_i)
    sdp && oclr[dprc_pkg::DPRC_PORT_B] |=> out_reg[dprc_pkg::DPRC_PORT_B] == '0)
    else $error("read-side output register not cleared");

  // the halves never meet, so both single-port memories may run at once
  a_single_apart: assert property (@(posedge clk_i) disable iff (reset_i)
    mode == dprc_pkg::DPRC_MODE_SINGLE && acc_reg[0] && acc_reg[1]
      |-> mem_addr[0][ADDR_W-1] != mem_addr[1][ADDR_W-1])
    else $error("single-port memories share a half");

endmodule : dprc_ram

/* File: rtl/dprc_pkg.sv */
// dprc_pkg: modes and shared constants of the clocked dual-port ram block.
// assumes a single system clock; the per-port "clocks" arrive as enable ticks.
package dprc_pkg;

  typedef enum logic [1:0] {
    DPRC_MODE_INDEP,
    DPRC_MODE_IO,
    DPRC_MODE_RW,
    DPRC_MODE_SINGLE
  } dprc_mode_e;

  localparam int DPRC_NPORTS      = 2;
  localparam int DPRC_PORT_A      = 0;
  localparam int DPRC_PORT_B      = 1;
  localparam int DPRC_LANE_W      = 8;
  localparam int DPRC_SP_MAX_BITS = 2048;

endpackage : dprc_pkg

/* File: rtl/dprc_mem.sv */
// dprc_mem: two-port storage array with byte lanes and registered read data.
// assumes callers present one access per port per cycle, already qualified.
`timescale 1ns/100ps
module dprc_mem #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 16
) (
  input  wire logic                                  clk_i,
  input  wire logic                                  reset_i,
  input  wire logic                                  a_we_i,
  input  wire logic                                  a_re_i,
  input  wire logic [ADDR_W-1:0]                     a_addr_i,
  input  wire logic [DATA_W-1:0]                     a_wdata_i,
  input  wire logic [DATA_W/dprc_pkg::DPRC_LANE_W-1:0] a_be_i,
  output logic      [DATA_W-1:0]                     a_q_o,
  input  wire logic                                  b_we_i,
  input  wire logic                                  b_re_i,
  input  wire logic [ADDR_W-1:0]                     b_addr_i,
  input  wire logic [DATA_W-1:0]                     b_wdata_i,
  input  wire logic [DATA_W/dprc_pkg::DPRC_LANE_W-1:0] b_be_i,
  output logic      [DATA_W-1:0]                     b_q_o
);
  localparam int LANES = DATA_W / dprc_pkg::DPRC_LANE_W;
  localparam int LW    = dprc_pkg::DPRC_LANE_W;

  logic [DATA_W-1:0] mem [2**ADDR_W];

  // port b is applied last, so it wins a same-address write collision
  always_ff @(posedge clk_i) begin
    for (int l = 0; l < LANES; l++) begin
      if (a_we_i && a_be_i[l]) begin
        mem[a_addr_i][l*LW +: LW] <= a_wdata_i[l*LW +: LW];
      end
      if (b_we_i && b_be_i[l]) begin
        mem[b_addr_i][l*LW +: LW] <= b_wdata_i[l*LW +: LW];
      end
    end
  end

  // read data held between reads; old data on a read-during-write
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      a_q_o <= '0;
    end else if (a_re_i) begin
      a_q_o <= mem[a_addr_i];
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      b_q_o <= '0;
    end else if (b_re_i) begin
      b_q_o <= mem[b_addr_i];
    end
  end

endmodule : dprc_mem

/* File: bench/dprc_fabric.sv */
// dprc_fabric: fabric-side requester for one ram port, two strobes per start, the second a read.
// assumes the bench holds ce and clear itself; ticks are one cycle wide.
`timescale 1ns/100ps
module dprc_fabric (
  input  wire logic        clk_i,
  input  wire logic        start_i,
  input  wire logic        wr_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic [1:0]  be_i,
  input  wire logic [1:0]  gap_i,
  output logic             busy_o = 1'b0,
  output logic             tick_o = 1'b0,
  output logic             otick_o = 1'b0,
  output logic             wren_o = 1'b0,
  output logic             rden_o = 1'b0,
  output logic [7:0]       addr_o = 8'h00,
  output logic [15:0]      wdata_o = 16'h0000,
  output logic [1:0]       be_o = 2'h0
);
  always begin
    @(posedge clk_i iff start_i);
    @(negedge clk_i);
    busy_o  = 1'b1;
    tick_o  = 1'b1;
    wren_o  = wr_i;
    rden_o  = !wr_i;
    addr_o  = addr_i;
    wdata_o = wdata_i;
    be_o    = be_i;
    @(negedge clk_i);
    tick_o  = 1'b0;
    wren_o  = 1'b0;
    // released lines must not keep their last value
    wdata_o = ~wdata_o;
    be_o    = ~be_o;
    // gap sets a prompt or a slow second strobe, never before edge n+2
    repeat (gap_i + 1) @(negedge clk_i);
    tick_o  = 1'b1;
    otick_o = 1'b1;
    rden_o  = 1'b1;
    @(negedge clk_i);
    tick_o  = 1'b0;
    otick_o = 1'b0;
    rden_o  = 1'b0;
    addr_o  = ~addr_o;
    busy_o  = 1'b0;
  end
endmodule : dprc_fabric

/* File: bench/dprc_ram_bench.sv */
// dprc_ram_bench: random and corner accesses in every clocking mode.
// assumes default widths (8-bit address, 16-bit data, two lanes).
`timescale 1ns/100ps
module dprc_ram_bench;
  logic        clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic [1:0]  mode = 2'h0, ce = 2'h3, clr = 2'h0, oclr = 2'h0, start = 2'h0, oce = 2'h3;
  logic        sdp = 1'b0, bypass = 1'b0, wr = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic [1:0]  be = 2'h0, gap = 2'h0;
  logic [31:0] seed = 32'h7c577d7f;
  logic [15:0] ref_mem [256];
  logic        ref_ok [256];
  int          failures = 0;
  int          n_compared = 0;
  wire [1:0]   busy, tick, otick, wren, rden;
  wire [7:0]   ad [2];
  wire [15:0]  wd [2];
  wire [1:0]   bl [2];
  wire [15:0]  rd_a, rd_b;

  for (genvar p = 0; p < 2; p++) begin : g_port
    dprc_fabric u_fab (.clk_i(clk_i), .start_i(start[p]), .wr_i(wr), .addr_i(addr),
      .wdata_i(wdata), .be_i(be), .gap_i(gap), .busy_o(busy[p]), .tick_o(tick[p]),
      .otick_o(otick[p]), .wren_o(wren[p]), .rden_o(rden[p]), .addr_o(ad[p]),
      .wdata_o(wd[p]), .be_o(bl[p]));
  end

  dprc_ram dut (.clk_i(clk_i), .reset_i(reset_i), .mode_i(mode), .sdp_i(sdp),
    .out_bypass_i(bypass), .a_in_tick_i(tick[0]), .a_in_ce_i(ce[0]), .a_in_clr_i(clr[0]),
    .a_out_tick_i(otick[0]), .a_out_ce_i(oce[0]), .a_out_clr_i(oclr[0]), .a_addr_i(ad[0]),
    .a_wdata_i(wd[0]), .a_wren_i(wren[0]), .a_byteen_i(bl[0]), .a_rdata_o(rd_a),
    .b_in_tick_i(tick[1]), .b_in_ce_i(ce[1]), .b_in_clr_i(clr[1]),
    .b_out_tick_i(otick[1]), .b_out_ce_i(oce[1]), .b_out_clr_i(oclr[1]), .b_addr_i(ad[1]),
    .b_wdata_i(wd[1]), .b_wren_i(wren[1]), .b_rden_i(rden[1]), .b_byteen_i(bl[1]),
    .b_rdata_o(rd_b));

  initial forever #2.5 clk_i = ~clk_i;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // single-port mode puts each port in its own half
  function automatic logic [7:0] idx(input int p, input logic [7:0] a);
    return (mode == 2'h3) ? {p[0], a[6:0]} : a;
  endfunction : idx

  task automatic stop_test();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // upd low marks an access that the reference model must not record
  task automatic access(input int p, input logic w, input logic [7:0] a,
                        input logic [15:0] d, input logic [1:0] b, input logic upd);
    int          n;
    logic [15:0] m;
    wr = w;
    addr = a;
    wdata = d;
    be = b;
    gap = rnd() % 3;
    start[p] = 1'b1;
    @(negedge clk_i);
    start[p] = 1'b0;
    n = 0;
    do begin
      @(negedge clk_i);
      #1;
      n++;
    end while (busy[p] === 1'b1 && n < 20);
    if (n >= 20) failures++;
    m = ref_mem[idx(p, a)];
    for (int l = 0; l < 2; l++) if (w && upd && b[l]) m[l*8 +: 8] = d[l*8 +: 8];
    if (w && upd) begin
      ref_mem[idx(p, a)] = m;
      ref_ok[idx(p, a)] = 1'b1;
    end
    if (!w && ref_ok[idx(p, a)]) check(p ? rd_b : rd_a, m);
  endtask : access

  task automatic run_mode(input logic [1:0] m, input logic s);
    int   p;
    logic w, sd;
    mode = m;
    sdp = s;
    bypass = rnd() % 2;
    reset_i = 1'b1;
    repeat (2) @(negedge clk_i);
    reset_i = 1'b0;
    for (int i = 0; i < 256; i++) ref_ok[i] = 1'b0;
    sd = (m == 2'h2) || (m == 2'h1 && s);
    repeat (60) begin
      p = rnd() % 2;
      w = sd ? (p == 0) : rnd() % 2;
      // refused in simple dual-port: port b tries to write
      if (sd && p == 1 && rnd() % 6 == 0) access(1, 1'b1, rnd() & 8'h8f, rnd(), 2'h3, 1'b0);
      else access(p, w, rnd() & 8'h8f, rnd(), rnd() % 4, 1'b1);
    end
  endtask : run_mode

  initial begin
    repeat (6) @(negedge clk_i);
    reset_i = 1'b0;
    check(rd_a, 16'h0000);
    run_mode(2'h0, 1'b0);
    run_mode(2'h1, 1'b1);
    run_mode(2'h2, 1'b0);
    run_mode(2'h1, 1'b0);
    access(0, 1'b1, 8'h07, 16'hbeef, 2'h3, 1'b1);
    access(0, 1'b0, 8'h07, 16'h0000, 2'h0, 1'b1);
    oclr[0] = 1'b1;
    #1;
    check(rd_a, 16'h0000);
    @(negedge clk_i);
    oclr[0] = 1'b0;
    #1;
    check(rd_a, bypass ? 16'hbeef : 16'h0000);
    clr[0] = 1'b1;
    access(0, 1'b1, 8'h07, 16'h1111, 2'h3, 1'b0);
    clr[0] = 1'b0;
    access(0, 1'b0, 8'h07, 16'h0000, 2'h0, 1'b1);
    // output enable low: the output register keeps the earlier read
    oce[0] = 1'b0;
    access(0, 1'b1, 8'h40, 16'h2222, 2'h3, 1'b0);
    access(0, 1'b0, 8'h40, 16'h0000, 2'h0, 1'b0);
    check(rd_a, bypass ? 16'h2222 : 16'hbeef);
    oce[0] = 1'b1;
    run_mode(2'h3, 1'b0);
    access(0, 1'b1, 8'h05, 16'haaaa, 2'h3, 1'b1);
    access(1, 1'b1, 8'h05, 16'h5555, 2'h3, 1'b1);
    access(0, 1'b0, 8'h05, 16'h0000, 2'h0, 1'b1);
    access(1, 1'b0, 8'h05, 16'h0000, 2'h0, 1'b1);
    ce[1] = 1'b0;
    access(1, 1'b1, 8'h05, 16'h1234, 2'h3, 1'b0);
    check(rd_b, 16'h5555);
    ce[1] = 1'b1;
    clr[1] = 1'b1;
    @(negedge clk_i);
    clr[1] = 1'b0;
    #1;
    check(rd_b, bypass ? 16'h5555 : 16'h0000);
    access(1, 1'b0, 8'h05, 16'h0000, 2'h0, 1'b1);
    stop_test();
  end

  // whole run is under two thousand cycles; this allows over ten times that
  initial begin
    #100000;
    failures++;
    stop_test();
  end
endmodule : dprc_ram_bench
